// ==== core/ge_cmp_pkg.sv ====
// Package: field layout, opcodes and types of the greater-or-equal compare unit
package ge_cmp_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned IDX_W   = 5;
    localparam int unsigned IMM_W   = 16;
    localparam int unsigned OP_W    = 6;
    localparam int unsigned XOP_W   = 6;
    localparam int unsigned SHF_W   = 5;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned FA_HI   = 31;
    localparam int unsigned FA_LO   = 27;
    localparam int unsigned FB_HI   = 26;
    localparam int unsigned FB_LO   = 22;
    localparam int unsigned FC_HI   = 21;
    localparam int unsigned FC_LO   = 17;
    localparam int unsigned XOP_HI  = 16;
    localparam int unsigned XOP_LO  = 11;
    localparam int unsigned SHF_HI  = 10;
    localparam int unsigned SHF_LO  = 6;
    localparam int unsigned IMM_HI  = 21;
    localparam int unsigned IMM_LO  = 6;
    localparam int unsigned OP_HI   = 5;
    localparam int unsigned OP_LO   = 0;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [OP_W-1:0]  OP_RTYPE  = 6'h3a;
    localparam logic [OP_W-1:0]  OP_GEI    = 6'h08;
    localparam logic [OP_W-1:0]  OP_GEUI   = 6'h28;
    localparam logic [XOP_W-1:0] XOP_GE    = 6'h08;
    localparam logic [XOP_W-1:0] XOP_GEU   = 6'h28;
    localparam logic [XOP_W-1:0] XOP_LT    = 6'h10;
    localparam logic [SHF_W-1:0] SHF_ZERO  = 5'h00;
    localparam logic [IMM_W-1:0] ZERO_HALF = 16'h0000;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum {CMP_NONE, CMP_GE, CMP_GEU, CMP_GEI, CMP_GEUI, CMP_LT} cmp_op_t;

    typedef struct packed {
        logic [WORD_W-1:0] first_source_reg;
        logic [WORD_W-1:0] second_source_reg;
    } operands_t;

    typedef struct packed {
        logic              valid;
        logic [IDX_W-1:0]  destination_reg;
        logic [WORD_W-1:0] value;
    } writeback_t;

endpackage : ge_cmp_pkg

// ==== core/ge_cmp_decode.sv ====
// Decoder of the compare instruction words
module ge_cmp_decode
(
    // Instruction word
    input  wire logic [31:0]             i_word,
    // Decoded fields
    output ge_cmp_pkg::cmp_op_t          o_op,
    output logic [ge_cmp_pkg::IDX_W-1:0] o_src_idx_a,
    output logic [ge_cmp_pkg::IDX_W-1:0] o_src_idx_b,
    output logic [ge_cmp_pkg::IDX_W-1:0] o_dst_idx,
    output logic [ge_cmp_pkg::IMM_W-1:0] o_immediate_half_word
);
    wire logic [ge_cmp_pkg::OP_W-1:0]  op_field;
    wire logic [ge_cmp_pkg::XOP_W-1:0] xop_field;
    wire logic                         is_rtype;
    wire logic                         shf_zero;

    assign op_field  = i_word[ge_cmp_pkg::OP_HI:ge_cmp_pkg::OP_LO];
    assign xop_field = i_word[ge_cmp_pkg::XOP_HI:ge_cmp_pkg::XOP_LO];
    assign shf_zero  = i_word[ge_cmp_pkg::SHF_HI:ge_cmp_pkg::SHF_LO] == ge_cmp_pkg::SHF_ZERO;
    assign is_rtype  = (op_field == ge_cmp_pkg::OP_RTYPE) && shf_zero;

    assign o_src_idx_a           = i_word[ge_cmp_pkg::FA_HI:ge_cmp_pkg::FA_LO];
    assign o_src_idx_b           = i_word[ge_cmp_pkg::FB_HI:ge_cmp_pkg::FB_LO];
    assign o_immediate_half_word = i_word[ge_cmp_pkg::IMM_HI:ge_cmp_pkg::IMM_LO];
    // Immediate forms write the second register field
    assign o_dst_idx = (op_field == ge_cmp_pkg::OP_RTYPE)
                     ? i_word[ge_cmp_pkg::FC_HI:ge_cmp_pkg::FC_LO]
                     : i_word[ge_cmp_pkg::FB_HI:ge_cmp_pkg::FB_LO];

    assign o_op = (is_rtype && xop_field == ge_cmp_pkg::XOP_GE)  ? ge_cmp_pkg::CMP_GE
                : (is_rtype && xop_field == ge_cmp_pkg::XOP_GEU) ? ge_cmp_pkg::CMP_GEU
                : (is_rtype && xop_field == ge_cmp_pkg::XOP_LT)  ? ge_cmp_pkg::CMP_LT
                : (op_field == ge_cmp_pkg::OP_GEI)  ? ge_cmp_pkg::CMP_GEI
                : (op_field == ge_cmp_pkg::OP_GEUI) ? ge_cmp_pkg::CMP_GEUI
                : ge_cmp_pkg::CMP_NONE;
endmodule : ge_cmp_decode

// ==== core/ge_gt_compare_unit.sv ====
// Greater-or-equal compare datapath with decode and registered write-back
module ge_gt_compare_unit
(
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_reset,
    // Issue from the instruction decoder
    input  wire logic                     i_valid,
    input  wire logic [31:0]              i_word,
    input  wire ge_cmp_pkg::operands_t    i_operands,
    // Write-back to the register file
    output ge_cmp_pkg::writeback_t        o_wb,
    output logic                          o_illegal
);
    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    ge_cmp_pkg::cmp_op_t                  op;
    logic [ge_cmp_pkg::IDX_W-1:0]         dst_idx;
    logic [ge_cmp_pkg::IMM_W-1:0]         immediate_half_word;

    ge_cmp_decode u_decode
    (
        .i_word                (i_word),
        .o_op                  (op),
        .o_src_idx_a           (),
        .o_src_idx_b           (),
        .o_dst_idx             (dst_idx),
        .o_immediate_half_word (immediate_half_word)
    );

    // ----------------------------------------------------------------
    // Compare
    // ----------------------------------------------------------------
    wire logic [31:0] first_source_reg;
    wire logic [31:0] second_source_reg;
    wire logic [31:0] imm_sext;
    wire logic [31:0] imm_zext;
    wire logic        ge_s;
    wire logic        ge_u;
    wire logic        gei_s;
    wire logic        geui_u;
    wire logic        lt_s;
    wire logic        hit;
    logic             result_bit;

    assign first_source_reg  = i_operands.first_source_reg;
    assign second_source_reg = i_operands.second_source_reg;
    assign imm_sext = {{ge_cmp_pkg::IMM_W{immediate_half_word[ge_cmp_pkg::IMM_W-1]}},
                       immediate_half_word};
    assign imm_zext = {ge_cmp_pkg::ZERO_HALF, immediate_half_word};
    assign ge_s   = $signed(first_source_reg) >= $signed(second_source_reg);
    assign ge_u   = first_source_reg >= second_source_reg;
    assign gei_s  = $signed(first_source_reg) >= $signed(imm_sext);
    assign geui_u = first_source_reg >= imm_zext;
    // Greater-than arrives as less-than with swapped operands
    assign lt_s   = $signed(first_source_reg) < $signed(second_source_reg);
    assign hit    = i_valid && (op != ge_cmp_pkg::CMP_NONE);

    always_comb
    begin
        case (op)
            ge_cmp_pkg::CMP_GE:   result_bit = ge_s;
            ge_cmp_pkg::CMP_GEU:  result_bit = ge_u;
            ge_cmp_pkg::CMP_GEI:  result_bit = gei_s;
            ge_cmp_pkg::CMP_GEUI: result_bit = geui_u;
            ge_cmp_pkg::CMP_LT:   result_bit = lt_s;
            default:              result_bit = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Next write-back value
    // ----------------------------------------------------------------
    ge_cmp_pkg::writeback_t wb_r;
    ge_cmp_pkg::writeback_t wb_nxt;
    logic                   illegal_r;
    logic                   illegal_nxt;

    // Only bit 0 carries the outcome, the upper bits are always clear
    assign wb_nxt = '{valid:           hit,
                      destination_reg: dst_idx,
                      value:           {{(ge_cmp_pkg::WORD_W-1){1'b0}}, result_bit}};
    // A valid word that no compare claims is flagged instead of written
    assign illegal_nxt = i_valid && !hit;

    // ----------------------------------------------------------------
    // Write-back register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wb_r      <= '0;
            illegal_r <= 1'b0;
        end
        else
        begin
            wb_r      <= wb_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_wb      = wb_r;
    assign o_illegal = illegal_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_GE_SIGNED: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GE |=> o_wb.valid
        && o_wb.value[0] == ($signed($past(first_source_reg)) >= $signed($past(second_source_reg))))
        else $error("signed register compare wrong");
    AST_GE_DECODE: assert property (@(posedge i_clk) disable iff (i_reset)
        i_word[5:0] == 6'h3a && i_word[16:11] == 6'h08 && i_word[10:6] == 5'h00
        |-> op == ge_cmp_pkg::CMP_GE)
        else $error("signed register form not decoded");
    AST_GEI_SIGNED: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && i_word[5:0] == 6'h08 |=> o_wb.destination_reg == $past(i_word[26:22])
        && o_wb.value[0] == ($signed($past(first_source_reg))
                             >= $signed({{16{$past(i_word[21])}}, $past(i_word[21:6])})))
        else $error("signed immediate compare wrong");
    AST_GEI_DECODE: assert property (@(posedge i_clk) disable iff (i_reset)
        i_word[5:0] == 6'h08 |-> op == ge_cmp_pkg::CMP_GEI)
        else $error("signed immediate form not decoded");
    AST_GEU: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEU
        |=> o_wb.value[0] == ($past(first_source_reg) >= $past(second_source_reg)))
        else $error("unsigned register compare wrong");
    AST_GEU_DECODE: assert property (@(posedge i_clk) disable iff (i_reset)
        i_word[5:0] == 6'h3a && i_word[16:11] == 6'h28 && i_word[10:6] == 5'h00
        |-> op == ge_cmp_pkg::CMP_GEU)
        else $error("unsigned register form not decoded");
    AST_GEUI: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEUI
        |=> o_wb.value[0] == ($past(first_source_reg) >= {16'h0000, $past(i_word[21:6])}))
        else $error("unsigned immediate compare wrong");
    AST_GEUI_DECODE: assert property (@(posedge i_clk) disable iff (i_reset)
        i_word[5:0] == 6'h28 |-> op == ge_cmp_pkg::CMP_GEUI)
        else $error("unsigned immediate form not decoded");
    AST_LT: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_LT
        |=> o_wb.value[0] == ($signed($past(first_source_reg)) < $signed($past(second_source_reg))))
        else $error("signed less-than compare wrong");
    AST_UPPER_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
        o_wb.value[31:1] == 31'h0000_0000)
        else $error("result upper bits not clear");

    // ----------------------------------------------------------------
    // Destination, refusal and boundary checks
    // ----------------------------------------------------------------
    AST_GE_DEST: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GE
        |=> o_wb.valid && o_wb.destination_reg == $past(i_word[21:17]))
        else $error("signed register compare wrote the wrong register");

    AST_GEU_DEST: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEU
        |=> o_wb.valid && o_wb.destination_reg == $past(i_word[21:17]))
        else $error("unsigned register compare wrote the wrong register");

    AST_GEUI_DEST: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEUI
        |=> o_wb.valid && o_wb.destination_reg == $past(i_word[26:22]))
        else $error("unsigned immediate compare wrote the wrong register");

    AST_LT_DEST: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_LT
        |=> o_wb.valid && o_wb.destination_reg == $past(i_word[21:17]))
        else $error("less-than compare wrote the wrong register");

    AST_REFUSED: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_NONE
        |=> o_illegal && !o_wb.valid)
        else $error("unknown word not refused");

    AST_GEI_ACCEPT: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEI
        |=> o_wb.valid && !o_illegal)
        else $error("signed immediate compare not written back");

    AST_GE_SELF: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GE && first_source_reg == second_source_reg
        |=> o_wb.value[0])
        else $error("signed compare of equal operands not true");

    AST_GEU_ZERO: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEU && second_source_reg == 32'h0000_0000
        |=> o_wb.value[0])
        else $error("unsigned compare against zero not true");

    AST_LT_SELF: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_LT && first_source_reg == second_source_reg
        |=> !o_wb.value[0])
        else $error("less-than of equal operands not false");

    // Greater-than is the less-than result read with the operands swapped
    AST_GT_SWAP: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_LT
        |=> o_wb.value[0] == ($signed($past(second_source_reg))
                              > $signed($past(first_source_reg))))
        else $error("swapped greater-than result wrong");

    // The most negative immediate has no predecessor, so it is left out
    AST_GTI_PLUS_ONE: assert property (@(posedge i_clk) disable iff (i_reset)
        i_valid && op == ge_cmp_pkg::CMP_GEI && immediate_half_word != 16'h8000
        |=> o_wb.value[0] == ($signed($past(first_source_reg))
                              > ($signed($past(imm_sext)) - 32'sh0000_0001)))
        else $error("greater-than immediate result wrong");
endmodule : ge_gt_compare_unit

// ==== testbench/cmp_regfile_model.sv ====
// Register file model that feeds the compare unit and takes its write-back
module cmp_regfile_model
(
    // Clock
    input  wire logic                   i_clk,
    // Read indices and write-back
    input  wire logic [4:0]             i_idx_a,
    input  wire logic [4:0]             i_idx_b,
    input  wire ge_cmp_pkg::writeback_t i_wb,
    // Operands
    output ge_cmp_pkg::operands_t       o_operands
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] regs [32];
    initial regs = '{default: 32'h0};
    assign o_operands = {regs[i_idx_a], regs[i_idx_b]};
    // The write lands after the unit has sampled the next operands
    always @(posedge i_clk)
        if (i_wb.valid)
            regs[i_wb.destination_reg] <= i_wb.value;
endmodule : cmp_regfile_model

// ==== testbench/ge_gt_compare_unit_tb.sv ====
// Self-checking bench of the greater-or-equal compare unit
module ge_gt_compare_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   i_clk;
    logic                   i_reset;
    logic                   i_valid;
    logic [31:0]            i_word;
    ge_cmp_pkg::operands_t  i_operands;
    ge_cmp_pkg::writeback_t o_wb;
    logic                   o_illegal;
    int                     n_errors;
    int                     n_tests;
    logic [31:0]            seed;
    logic [38:0]            exp_q[$];
    logic [31:0]            vals[6] = '{32'h8000_0000, 32'h7fff_ffff, 32'h0, 32'hffff_ffff,
                                        32'hffff_8000, 32'h0000_7fff};
    int                     lims[4] = '{32766, -32769, 0, -1};
    logic [5:0]             xops[4] = '{6'h08, 6'h28, 6'h10, 6'h20};

    cmp_regfile_model rf (.i_clk(i_clk), .i_idx_a(i_word[31:27]), .i_idx_b(i_word[26:22]),
                          .i_wb(o_wb), .o_operands(i_operands));
    ge_gt_compare_unit dut (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid),
                            .i_word(i_word), .i_operands(i_operands), .o_wb(o_wb),
                            .o_illegal(o_illegal));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Reference: {valid, illegal, destination, value}
    function automatic logic [38:0] model(logic [31:0] w, logic [31:0] a, logic [31:0] b);
        int     si = $signed(w[21:6]);
        longint ui = w[21:6];
        if (w[5:0] == 6'h3a && w[10:6] == 5'h00 && w[16:11] inside {6'h08, 6'h28, 6'h10})
            return {2'b10, w[21:17], 31'h0, w[16:11] == 6'h08 ? int'(a) >= int'(b)
                    : w[16:11] == 6'h28 ? a >= b : int'(a) < int'(b)};
        if (w[5:0] == 6'h08)
            return {2'b10, w[26:22], 31'h0, int'(a) >= si};
        if (w[5:0] == 6'h28)
            return {2'b10, w[26:22], 31'h0, longint'(a) >= ui};
        return {2'b01, 37'h0};
    endfunction : model

    task automatic check(string nm, logic [38:0] seen, logic [38:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic retire();
        logic [38:0] e;
        if (exp_q.size() == 0)
            return;
        e = exp_q.pop_front();
        check("flags", {o_wb.valid, o_illegal}, e[38:37]);
        if (e[38])
            check("result", {o_wb.destination_reg, o_wb.value}, e[36:0]);
    endtask : retire

    task automatic issue(logic [31:0] w, logic [31:0] va, logic [31:0] vb, logic [38:0] e);
        @(negedge i_clk);
        retire();
        rf.regs[w[31:27]] = va;
        rf.regs[w[26:22]] = vb;
        i_valid = 1'b1;
        i_word = w;
        exp_q.push_back(e);
    endtask : issue

    task automatic run(logic [31:0] w, logic [31:0] va, logic [31:0] vb);
        issue(w, va, vb, model(w, w[31:27] == w[26:22] ? vb : va, vb));
    endtask : run

    task automatic idle();
        @(negedge i_clk);
        retire();
        i_valid = 1'b0;
        exp_q.push_back(39'h0);
    endtask : idle

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : end_of_test

    initial
    begin
        repeat (100000) @(posedge i_clk);
        n_errors++;
        end_of_test();
    end

    initial
    begin
        logic [31:0] w;
        logic [31:0] sel;
        seed = 32'h0001_118f;
        n_errors = 0;
        n_tests = 0;
        i_reset = 1'b1;
        i_valid = 1'b0;
        i_word = 32'h0;
        repeat (10) @(negedge i_clk);
        check("reset", {o_wb, o_illegal}, 39'h0);
        i_reset = 1'b0;
        foreach (xops[x])
            for (int i = 0; i < 6; i++)
            begin
                run({5'h01, 5'h02, 5'h03, xops[x], 11'h03a}, vals[i], vals[5 - i]);
                run({5'h01, 5'h02, 5'h03, xops[x], 11'h03a}, vals[i], vals[i]);
            end
        run({5'h01, 5'h02, 5'h03, 6'h08, 5'h01, 6'h3a}, 32'h1, 32'h2);
        foreach (vals[i])
            foreach (vals[j])
            begin
                run({5'h04, 5'h05, vals[j][15:0], 6'h08}, vals[i], 32'h0);
                run({5'h04, 5'h05, vals[j][15:0], 6'h28}, vals[i], 32'h0);
                issue({5'h02, 5'h01, 5'h06, 6'h10, 11'h03a}, vals[j], vals[i],
                      {2'b10, 5'h06, 31'h0, int'(vals[i]) > int'(vals[j])});
            end
        foreach (lims[k])
            foreach (vals[i])
                issue({5'h07, 5'h08, 16'(lims[k] + 1), 6'h08}, vals[i], 32'h0,
                      {2'b10, 5'h08, 31'h0, int'(vals[i]) > lims[k]});
        repeat (400)
        begin
            sel = rnd();
            w = rnd();
            if (sel[1:0] == 2'h0)
                w[16:0] = {xops[sel[3:2]], 11'h03a};
            else if (sel[1:0] != 2'h3)
                w[5:0] = sel[0] ? 6'h08 : 6'h28;
            if (sel[4])
                idle();
            run(w, rnd(), rnd());
        end
        idle();
        idle();
        end_of_test();
    end
endmodule : ge_gt_compare_unit_tb
